// [bench/ssp_far_model.sv]
// Far-side model: SPI partner in both roles, I2C master making conditions.
// Assumes pulled-up open-drain lines; an enable high pulls its line low.
`timescale 1ns/1ps
module ssp_far_model (
  input wire logic clk,
  input wire logic sck_oe,
  input wire logic sda_oe,
  input wire logic scl_oe,
  input wire logic lvl,
  input wire logic sck,
  input wire logic serial_out_pin,
  input wire logic smp_rise,
  output logic serial_in_pin,
  output logic sda,
  output logic scl,
  output logic sck_far,
  output logic [7:0] spi_byte
);
  logic far_sda_low; // Model pulls data low
  logic far_scl_low; // Model pulls clock low
  logic far_drive; // Model clocks the port as a master
  // Undriven data line shows the inverse, so a stale level never passes
  assign serial_in_pin = (sck_oe || far_drive) ? lvl : ~lvl;
  // Far slave takes the data out on its sampling edge; only the last eight count
  always @(sck) begin
    if (sck_oe && sck == smp_rise) begin
      spi_byte <= {spi_byte[6:0], serial_out_pin};
    end
  end
  // Wired-and of both parties with the pull-up
  assign sda = ~(sda_oe | far_sda_low);
  assign scl = ~(scl_oe | far_scl_low);
  initial begin
    far_sda_low = 1'b0;
    far_scl_low = 1'b0;
    far_drive = 1'b0;
    sck_far = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Data edge while clock is high: falling for start, rising for stop
  task automatic cond(input logic is_start);
    far_sda_low <= ~is_start;
    repeat (8) @(posedge clk);
    far_sda_low <= is_start;
    repeat (8) @(posedge clk);
  endtask
  // One byte as far master: 16 clock edges, four cycles apart, data held meanwhile
  task automatic spi_clk();
    far_drive <= 1'b1;
    repeat (16) begin
      repeat (4) @(posedge clk);
      sck_far <= ~sck_far;
    end
    repeat (4) @(posedge clk);
    far_drive <= 1'b0;
  endtask
endmodule

// [bench/testbench.sv]
// Self-checking bench of the serial port: registers, SPI master bytes, I2C flags.
// Assumes a pulled-up I2C bus and a far-side model on the pins.
`timescale 1ns/1ps
`include "ssp_params.svh"
module testbench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic ack, tick = 1'b0, lvl = 1'b0;
  logic sck_o, sck_oe, sdo_o, sdo_oe, serial_in_pin, sda_o, sda_oe, sda, scl_o, scl_oe, scl;
  logic port_en, slew, byte_ev;
  logic [7:0] r, d;
  logic [1:0] m;
  logic sck_far; // Clock from the far master
  logic [7:0] spi_byte; // Byte the far slave took
  logic clock_polarity, cke, sample_phase;
  int seed = 32'hD99C5016;
  int err_total = 0;
  int comparisons = 0;
  int n;
  always #5 ref_clk = ~ref_clk;
  // Timer ticks run freely; only the timer-driven mode uses them
  always @(posedge ref_clk) tick <= ~tick;
  ssp_top u_ssp_top (.REF_CLK(ref_clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(dat), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .TMR_TICK_I(tick), .SCK_O(sck_o), .SCK_OE(sck_oe), .SCK_I(sck_far),
    .SDO_O(sdo_o), .SDO_OE(sdo_oe), .SDI_I(serial_in_pin), .SS_N_I(1'b1), .SDA_O(sda_o),
    .SDA_OE(sda_oe), .SDA_I(sda), .SCL_O(scl_o), .SCL_OE(scl_oe), .SCL_I(scl),
    .PORT_ENABLED(port_en), .SLEW_LIMIT(slew), .BYTE_EVENT(byte_ev));
  ssp_far_model u_ssp_far_model (.clk(ref_clk), .sck_oe(sck_oe), .sda_oe(sda_oe),
    .scl_oe(scl_oe), .lvl(lvl), .sck(sck_o), .serial_out_pin(sdo_o), .smp_rise(clock_polarity == cke),
    .serial_in_pin(serial_in_pin), .sda(sda), .scl(scl), .sck_far(sck_far), .spi_byte(spi_byte));
  ////////////////////////////////////////////////////////////////////////////////
  // Expected status readback: only the two phase bits stick
  function automatic logic [7:0] exp_stat(input logic [7:0] w);
    return {w[7:6], 6'h00};
  endfunction
  // A steady input level fills every bit of the byte
  function automatic logic [7:0] exp_rx(input logic l);
    return {8{l}};
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, v};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      err_total++;
      end_of_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    wb(0, `SSP_CTRL_ADR, 8'h00);
    chk(r, 8'h00);
    wb(0, `SSP_STAT_ADR, 8'h00);
    chk(r, 8'h00);
    wb(1, `SSP_STAT_ADR, 8'hFF);
    wb(0, `SSP_STAT_ADR, 8'h00);
    chk(r, exp_stat(8'hFF));
    wb(0, 8'h40, 8'h00);
    chk(r, 8'h00);
    // SPI master bytes over all four clock sources, random phase and data
    for (int i = 0; i < 8; i++) begin
      m = i[1:0];
      {clock_polarity, cke, sample_phase} = 3'($random(seed));
      lvl <= 1'($random(seed));
      d = 8'($random(seed));
      wb(1, `SSP_CTRL_ADR, {3'b001, clock_polarity, 2'b00, m});
      wb(1, `SSP_STAT_ADR, {sample_phase, cke, 6'h3F});
      @(negedge ref_clk);
      chk(sck_o, clock_polarity);
      chk({port_en, sck_oe}, 2'b11);
      wb(1, `SSP_BUF_ADR, d);
      wb(1, `SSP_BUF_ADR, ~d);
      n = 0;
      while (byte_ev !== 1'b1 && n < 3000) begin
        @(posedge ref_clk);
        n++;
      end
      chk(n < 3000, 1'b1);
      if (n >= 3000) begin
        end_of_test();
      end
      chk(spi_byte, d);
      wb(0, `SSP_STAT_ADR, 8'h00);
      chk(r, {sample_phase, cke, 6'h01});
      wb(0, `SSP_BUF_ADR, 8'h00);
      chk(r, exp_rx(lvl));
      wb(0, `SSP_STAT_ADR, 8'h00);
      chk(r[0], 1'b0);
      wb(0, `SSP_CTRL_ADR, 8'h00);
      chk(r[7:6], 2'b10);
      wb(1, `SSP_CTRL_ADR, {r[7:6] & 2'b01, r[5:0]});
      wb(0, `SSP_CTRL_ADR, 8'h00);
      chk(r[7], 1'b0);
      @(negedge ref_clk);
      chk(sck_o, clock_polarity);
    end
    wb(1, `SSP_CTRL_ADR, 8'h00);
    @(negedge ref_clk);
    chk({port_en, sck_oe, sdo_oe}, 3'b000);
    // SPI slave without select: first byte lands, the next one overruns
    wb(1, `SSP_STAT_ADR, 8'h00);
    wb(1, `SSP_CTRL_ADR, 8'h25);
    @(negedge ref_clk);
    chk({port_en, sck_oe, sdo_oe}, 3'b101);
    u_ssp_far_model.spi_clk();
    wb(0, `SSP_STAT_ADR, 8'h00);
    chk(r[0], 1'b1);
    d = exp_rx(lvl);
    lvl <= ~lvl;
    u_ssp_far_model.spi_clk();
    wb(0, `SSP_CTRL_ADR, 8'h00);
    chk(r[6], 1'b1);
    wb(0, `SSP_BUF_ADR, 8'h00);
    chk(r, d);
    // I2C slave: stretch, slew control and condition flags
    wb(1, `SSP_STAT_ADR, 8'h00);
    wb(1, `SSP_CTRL_ADR, 8'h26);
    @(negedge ref_clk);
    chk({port_en, scl_oe, slew}, 3'b111);
    wb(1, `SSP_CTRL_ADR, 8'h36);
    @(negedge ref_clk);
    chk(scl_oe, 1'b0);
    u_ssp_far_model.cond(1'b1);
    wb(0, `SSP_STAT_ADR, 8'h00);
    chk(r[4:3], 2'b01);
    u_ssp_far_model.cond(1'b0);
    wb(0, `SSP_STAT_ADR, 8'h00);
    chk(r[4:3], 2'b10);
    wb(1, `SSP_CTRL_ADR, 8'h16);
    wb(0, `SSP_STAT_ADR, 8'h00);
    chk(r[4:3], 2'b00);
    // I2C master: a buffer write sends one byte; busy shows in status
    wb(1, `SSP_SADR_ADR, 8'h03);
    wb(1, `SSP_CTRL_ADR, 8'h28);
    wb(1, `SSP_BUF_ADR, 8'hA5);
    wb(0, `SSP_STAT_ADR, 8'h00);
    chk(r[5:0], 6'h25);
    wb(1, `SSP_BUF_ADR, 8'h5A);
    wb(0, `SSP_CTRL_ADR, 8'h00);
    chk(r[7], 1'b1);
    repeat (300) @(posedge ref_clk);
    wb(0, `SSP_STAT_ADR, 8'h00);
    chk({r[2], r[0]}, 2'b00);
    end_of_test();
  end
endmodule

// [design/ssp_params.svh]
// Constants of the serial port: offsets, bit positions, reset values, divider counts.
// Included by the shifter, the top module and the bench; holds definitions only.
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
// Register byte offsets on the Wishbone bus
`define SSP_CTRL_ADR 8'h14
`define SSP_STAT_ADR 8'h94
`define SSP_BUF_ADR 8'h18
`define SSP_SADR_ADR 8'h1C
`define SSP_CMD_ADR 8'h20
// Reset values of the control and status registers
`define SSP_CTRL_RST 8'h00
`define SSP_STAT_RST 8'h00
// Control register bit positions
`define SSP_WRITE_COLLISION_FLAG 7
`define SSP_OVF 6
`define SSP_EN 5
`define SSP_CKP 4
// Status register writable bit positions
`define SSP_SMP 7
`define SSP_CKE 6
// Command register bit positions
`define SSP_C_START 0
`define SSP_C_RSTART 1
`define SSP_C_STOP 2
`define SSP_C_RCV 3
`define SSP_C_ACK 4
// Mode field codes
`define SSP_M_SPI_TMR 4'h3
`define SSP_M_SPI_SS 4'h4
`define SSP_M_SPI_NOSS 4'h5
`define SSP_M_I2C_7A 4'h6
`define SSP_M_I2C_10A 4'h7
`define SSP_M_I2C_MST 4'h8
`define SSP_M_I2C_FW 4'hB
`define SSP_M_I2C_7B 4'hE
`define SSP_M_I2C_10B 4'hF
// Half period of the master clock in REF_CLK cycles, minus one (divide by 4, 16, 64)
`define SSP_HALF_DIV4 9'h001
`define SSP_HALF_DIV16 9'h007
`define SSP_HALF_DIV64 9'h01F
// Last edge index of an SPI byte; last half-bit index of I2C byte phases
`define SSP_SPI_LAST 5'h10
`define SSP_I2C_TX_LAST 5'h11
`define SSP_I2C_RX_LAST 5'h0F
`define SSP_I2C_ACK_LAST 5'h01
`endif

// [design/ssp_pkg.sv]
// Types shared by the serial port modules: state codes and state records.
// Assumes nothing beyond the constants header.
package ssp_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SPI = 3'b001,
    ST_ICOND = 3'b010,
    ST_IBIT = 3'b011
  } ssp_state_t;
  // Kind of I2C master phase
  typedef enum logic [1:0] {
    K_TX = 2'b00,
    K_RX = 2'b01,
    K_ACK = 2'b10,
    K_STOP = 2'b11
  } ssp_kind_t;
  // Shifter state
  typedef struct packed {
    logic [7:0] tx;
    logic [7:0] rx;
    logic [2:0] cnt;
    logic done;
  } ssp_shift_t;
  // Whole state of the top module
  typedef struct packed {
    ssp_state_t st;
    ssp_kind_t kind;
    logic [7:0] ctl;
    logic sample_phase;
    logic cke;
    logic dna;
    logic stop;
    logic start;
    logic rw;
    logic ua;
    logic bf;
    logic [7:0] bufr;
    logic [7:0] sadr;
    logic [4:0] cmd;
    logic [8:0] div;
    logic [4:0] e;
    logic sck;
    logic sda_low;
    logic scl_low;
    logic p_sda;
    logic p_scl;
    logic p_sck;
    logic listen;
    logic addr_ph;
    logic ack;
    logic [7:0] dat;
    logic byte_ev;
  } ssp_top_t;
endpackage

// [design/ssp_shift_if.sv]
// Link between the port control logic and its byte shifter.
// Both ends run on the same clock; strobes are one-cycle pulses, except clear, held while the SPI slave is deselected.
`timescale 1ns/1ps
interface ssp_shift_if;
  logic clear; // Restart bit count
  logic load; // Load transmit byte
  logic [7:0] load_byte;
  logic out_step; // Advance transmit bit
  logic in_step; // Take one received bit
  logic in_bit;
  logic tx_bit; // Current output bit, msb first
  logic [7:0] rx_byte;
  logic done; // Eighth bit taken, one-cycle pulse
  modport ctl (output clear, load, load_byte, out_step, in_step, in_bit,
    input tx_bit, rx_byte, done);
  modport eng (input clear, load, load_byte, out_step, in_step, in_bit,
    output tx_bit, rx_byte, done);
endinterface

// [design/ssp_shifter.sv]
// Byte shifter: msb-first transmit and receive with an eight-bit count.
// Assumes the controller never loads and shifts in the same cycle.
`timescale 1ns/1ps
`include "ssp_params.svh"
module ssp_shifter import ssp_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  ssp_shift_if.eng sif
);
  ssp_shift_t q; // Registered state
  ssp_shift_t d; // Next state

  //////////////////////////////////////////////////////////////////////////
  // Next state: transmit shifts in ones so an idle open-drain line floats
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (sif.clear || sif.load) begin
      d.cnt = 3'h0;
    end
    if (sif.load) begin
      d.tx = sif.load_byte;
    end else if (sif.out_step) begin
      d.tx = {q.tx[6:0], 1'b1};
    end
    if (sif.in_step && !sif.clear) begin
      d.rx = {q.rx[6:0], sif.in_bit};
      d.cnt = q.cnt + 3'h1;
      d.done = (q.cnt == 3'h7);
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sif.tx_bit = q.tx[7];
  assign sif.rx_byte = q.rx;
  assign sif.done = q.done;

  //////////////////////////////////////////////////////////////////////////
  // Done only follows a taken bit
  shift_done_a: assert property (@(posedge clk) disable iff (rst)
    sif.done |-> $past(sif.in_step)) else $error("shifter done without bit");
endmodule

// [design/ssp_top.sv]
// Synchronous serial port status and control: SPI master/slave, I2C master/slave.
// Assumes a classic Wishbone master and pins synchronous to REF_CLK.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`include "ssp_params.svh"
module ssp_top import ssp_pkg::*; (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic TMR_TICK_I,
  output logic SCK_O,
  output logic SCK_OE,
  input wire logic SCK_I,
  output logic SDO_O,
  output logic SDO_OE,
  input wire logic SDI_I,
  input wire logic SS_N_I,
  output logic SDA_O,
  output logic SDA_OE,
  input wire logic SDA_I,
  output logic SCL_O,
  output logic SCL_OE,
  input wire logic SCL_I,
  output logic PORT_ENABLED,
  output logic SLEW_LIMIT,
  output logic BYTE_EVENT
);
  ssp_top_t q; // Registered state
  ssp_top_t d; // Next state
  ssp_shift_if sif();
  logic [3:0] mode; // Mode field
  logic en; // Port enable
  logic req; // New bus request
  logic tick; // Half-bit enable from the divider
  logic lead; // Current SPI edge is a leading edge
  logic shift_e; // Transmit edge
  logic mid_e; // Middle-of-bit edge
  logic samp; // Sampling edge
  logic rise; // SCL rising
  logic fall; // SCL falling
  logic collide; // Buffer write not allowed now
  logic ibit_low; // Master pulls SDA in a bit phase
  logic [8:0] half; // Divider reload
  logic [4:0] last; // Last half-bit of a master phase

  //////////////////////////////////////////////////////////////////////////
  // Mode decoding, used by the sequencer and the pin drivers
  function automatic logic f_spi_m(input logic [3:0] m);
    return m <= `SSP_M_SPI_TMR;
  endfunction
  function automatic logic f_spi_s(input logic [3:0] m);
    return (m == `SSP_M_SPI_SS) || (m == `SSP_M_SPI_NOSS);
  endfunction
  function automatic logic f_i2c_s(input logic [3:0] m);
    return (m == `SSP_M_I2C_7A) || (m == `SSP_M_I2C_10A) ||
      (m == `SSP_M_I2C_7B) || (m == `SSP_M_I2C_10B);
  endfunction
  function automatic logic f_i2c(input logic [3:0] m);
    return f_i2c_s(m) || (m == `SSP_M_I2C_MST) || (m == `SSP_M_I2C_FW);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic: bus access first so hardware sets win over clears
  always_comb begin
    d = q;
    mode = q.ctl[3:0];
    en = q.ctl[`SSP_EN];
    d.ack = 1'b0;
    d.byte_ev = 1'b0;
    sif.clear = 1'b0;
    sif.load = 1'b0;
    sif.load_byte = WB_DAT_I[7:0];
    sif.out_step = 1'b0;
    sif.in_step = 1'b0;
    sif.in_bit = SDI_I;
    req = WB_CYC_I && WB_STB_I && !q.ack;
    rise = SCL_I && !q.p_scl;
    fall = !SCL_I && q.p_scl;
    // Divider reload per mode; I2C master runs at 4*(address+1)
    case (mode[1:0])
      2'b00: half = `SSP_HALF_DIV4;
      2'b01: half = `SSP_HALF_DIV16;
      default: half = `SSP_HALF_DIV64;
    endcase
    if (mode == `SSP_M_I2C_MST) begin
      half = {q.sadr, 1'b1};
    end
    // SPI edge classes; edge 16 toggles no clock, but with cke set it still shifts and can sample
    lead = !q.e[0];
    shift_e = q.cke ? (lead && q.e != 5'h00) : !lead;
    mid_e = q.cke ? !lead : (lead && q.e != `SSP_SPI_LAST);
    samp = q.sample_phase ? shift_e : mid_e;
    collide = (q.st != ST_IDLE) ||
      ((mode == `SSP_M_I2C_MST) && q.cmd != 5'h00) ||
      (!f_spi_m(mode) && mode != `SSP_M_I2C_MST && q.e != 5'h00);
    case (q.kind)
      K_TX: last = `SSP_I2C_TX_LAST;
      K_RX: last = `SSP_I2C_RX_LAST;
      default: last = `SSP_I2C_ACK_LAST;
    endcase
    ibit_low = (q.kind == K_TX) ? (q.e < 5'h10 && !sif.tx_bit) : (q.kind == K_ACK);
    // Divider: one-cycle tick per half bit while a master sequence runs
    tick = 1'b0;
    if (q.st == ST_IDLE) begin
      d.div = half;
    end else if (mode == `SSP_M_SPI_TMR) begin
      tick = TMR_TICK_I; // Timer output halved by the sck toggle
    end else if (q.div == 9'h000) begin
      tick = 1'b1;
      d.div = half;
    end else begin
      d.div = q.div - 9'h001;
    end

    // Register access, answered one cycle after the request
    if (req) begin
      d.ack = 1'b1;
      d.dat = 8'h00; // Unmapped addresses read zero
      case (WB_ADR_I)
        `SSP_CTRL_ADR: d.dat = q.ctl;
        `SSP_STAT_ADR: d.dat = {q.sample_phase, q.cke, q.dna, q.stop, q.start,
          (mode == `SSP_M_I2C_MST) ? (q.st == ST_IBIT && q.kind == K_TX) : q.rw,
          q.ua, q.bf};
        `SSP_BUF_ADR: d.dat = q.bufr;
        `SSP_SADR_ADR: d.dat = q.sadr;
        `SSP_CMD_ADR: d.dat = {3'h0, q.cmd};
        default: d.dat = 8'h00;
      endcase
      if (!WB_WE_I && WB_ADR_I == `SSP_BUF_ADR) begin
        d.bf = 1'b0; // Reading the buffer empties it
      end
      if (WB_WE_I && WB_SEL_I[0]) begin
        case (WB_ADR_I)
          `SSP_CTRL_ADR: begin
            d.ctl[5:0] = WB_DAT_I[5:0];
            // Flags clear only by writing zero
            d.ctl[`SSP_WRITE_COLLISION_FLAG] = q.ctl[`SSP_WRITE_COLLISION_FLAG] && WB_DAT_I[`SSP_WRITE_COLLISION_FLAG];
            d.ctl[`SSP_OVF] = q.ctl[`SSP_OVF] && WB_DAT_I[`SSP_OVF];
          end
          `SSP_STAT_ADR: begin
            d.sample_phase = WB_DAT_I[`SSP_SMP];
            d.cke = WB_DAT_I[`SSP_CKE];
          end
          `SSP_SADR_ADR: begin
            d.sadr = WB_DAT_I[7:0];
            d.ua = 1'b0;
          end
          `SSP_CMD_ADR: begin
            // Requests are not queued while the master is busy
            if (mode == `SSP_M_I2C_MST && q.st == ST_IDLE && q.cmd == 5'h00) begin
              d.cmd = WB_DAT_I[4:0];
            end
          end
          `SSP_BUF_ADR: begin
            if (collide) begin
              d.ctl[`SSP_WRITE_COLLISION_FLAG] = 1'b1;
            end else begin
              sif.load = 1'b1;
              d.e = 5'h00;
              if (en && f_spi_m(mode)) begin
                d.st = ST_SPI; // Master transfer starts on the write
                d.div = half;
              end else if (en && mode == `SSP_M_I2C_MST) begin
                d.st = ST_IBIT;
                d.kind = K_TX;
                d.bf = 1'b1;
                d.dna = 1'b1;
              end
            end
          end
          default: d.dat = 8'h00;
        endcase
      end
    end

    // SPI master: 16 clock edges then a closing step
    if (q.st == ST_SPI && tick) begin
      if (q.e != `SSP_SPI_LAST) begin
        d.sck = !q.sck;
      end
      sif.out_step = shift_e;
      sif.in_step = samp;
      d.e = q.e + 5'h01;
      if (q.e == `SSP_SPI_LAST) begin
        d.st = ST_IDLE;
        d.e = 5'h00;
      end
    end
    if (q.st == ST_IDLE) begin
      d.sck = q.ctl[`SSP_CKP];
    end

    // SPI slave: count edges of the incoming clock while selected
    d.p_sck = SCK_I;
    if (en && f_spi_s(mode)) begin
      if (mode == `SSP_M_SPI_SS && SS_N_I) begin
        d.e = 5'h00;
        sif.clear = 1'b1;
      end else if (SCK_I != q.p_sck) begin
        sif.in_step = mid_e; // Relies on sample phase kept clear
        sif.out_step = shift_e;
        d.e = (q.e == 5'h0F) ? 5'h00 : q.e + 5'h01;
      end
    end

    // Completed byte from the shifter (SPI and I2C master)
    if (sif.done && !f_i2c_s(mode)) begin
      if (q.bf && !f_spi_m(mode)) begin
        d.ctl[`SSP_OVF] = 1'b1;
      end else begin
        d.bufr = sif.rx_byte;
        d.bf = 1'b1;
        d.byte_ev = 1'b1;
        d.dna = d.dna || f_i2c(mode);
      end
    end

    // I2C bus monitor: start and stop conditions seen on the pins
    d.p_sda = SDA_I;
    d.p_scl = SCL_I;
    if (en && f_i2c(mode) && SCL_I && q.p_scl && (SDA_I != q.p_sda)) begin
      d.start = !SDA_I;
      d.stop = SDA_I;
      d.rw = 1'b0;
      d.listen = !SDA_I;
      d.addr_ph = 1'b1;
      d.e = 5'h00;
      d.sda_low = 1'b0;
      sif.clear = 1'b1;
    end else if (en && f_i2c_s(mode) && q.listen) begin
      // I2C slave receive: bits on SCL rise, decisions on SCL fall
      if (rise) begin
        sif.in_step = q.e < 5'h08;
        sif.in_bit = SDA_I;
        if (q.e == 5'h08 && SDA_I) begin
          d.rw = 1'b0;
        end
        d.e = q.e + 5'h01;
      end else if (fall && q.e == 5'h08) begin
        if (q.addr_ph) begin
          if (sif.rx_byte[7:1] == q.sadr[7:1]) begin
            d.rw = sif.rx_byte[0];
            d.dna = 1'b0;
            d.addr_ph = 1'b0;
            d.ua = q.ua || mode == `SSP_M_I2C_10A || mode == `SSP_M_I2C_10B;
            d.sda_low = 1'b1;
          end else begin
            d.listen = 1'b0;
          end
        end else if (q.bf) begin
          d.ctl[`SSP_OVF] = 1'b1;
        end else begin
          d.bufr = sif.rx_byte;
          d.bf = 1'b1;
          d.dna = 1'b1;
          d.byte_ev = 1'b1;
          d.sda_low = 1'b1;
        end
      end else if (fall && q.e == 5'h09) begin
        d.sda_low = 1'b0;
        d.e = 5'h00;
      end
    end

    // I2C master: pick the next request, then walk its half bits
    if (en && mode == `SSP_M_I2C_MST) begin
      if (q.st == ST_IDLE && d.st == ST_IDLE && q.cmd != 5'h00) begin
        d.e = 5'h00;
        if (q.cmd[`SSP_C_START] || q.cmd[`SSP_C_RSTART]) begin
          d.st = ST_ICOND;
          d.kind = K_TX;
        end else if (q.cmd[`SSP_C_STOP]) begin
          d.st = ST_ICOND;
          d.kind = K_STOP;
        end else begin
          d.st = ST_IBIT;
          d.kind = q.cmd[`SSP_C_RCV] ? K_RX : K_ACK;
          sif.clear = 1'b1;
        end
      end else if (q.st == ST_ICOND && tick) begin
        d.e = q.e + 5'h01;
        case (q.e)
          5'h00: begin
            d.sda_low = (q.kind == K_STOP);
            d.scl_low = (q.kind == K_STOP);
          end
          5'h01: begin
            d.sda_low = 1'b1;
            d.scl_low = 1'b0;
          end
          default: begin
            d.sda_low = 1'b0;
            d.scl_low = (q.kind != K_STOP);
            d.st = ST_IDLE;
            d.e = 5'h00;
            d.cmd[2:0] = 3'h0;
          end
        endcase
      end else if (q.st == ST_IBIT && tick) begin
        d.e = q.e + 5'h01;
        d.scl_low = q.e[0];
        if (q.e[0]) begin
          sif.in_step = (q.kind == K_RX);
          sif.in_bit = SDA_I;
          sif.out_step = (q.kind == K_TX);
        end
        if (q.kind == K_TX && q.e == 5'h0F) begin
          d.bf = 1'b0;
        end
        if (q.e == last) begin
          d.st = ST_IDLE;
          d.e = 5'h00;
          d.cmd[4:3] = 2'h0;
        end
      end
    end

    // Disabled port: sequencing stops and condition flags clear
    if (!d.ctl[`SSP_EN]) begin
      d.start = 1'b0;
      d.stop = 1'b0;
      d.st = ST_IDLE;
      d.cmd = 5'h00;
      d.listen = 1'b0;
      d.sda_low = 1'b0;
      d.scl_low = 1'b0;
    end
  end

  // State register; all registers clear on reset
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  ssp_shifter u_shift (
    .clk(REF_CLK),
    .rst(RST),
    .sif(sif)
  );

  //////////////////////////////////////////////////////////////////////////
  // Outputs; open-drain lines only ever pull low
  assign WB_ACK_O = q.ack;
  assign WB_DAT_O = {24'h000000, q.dat};
  assign SCK_O = q.sck;
  assign SCK_OE = en && f_spi_m(mode);
  assign SDO_O = sif.tx_bit;
  assign SDO_OE = en && (f_spi_m(mode) ||
    (f_spi_s(mode) && (mode == `SSP_M_SPI_NOSS || !SS_N_I)));
  assign SDA_O = 1'b0;
  assign SCL_O = 1'b0;
  assign SDA_OE = en && f_i2c(mode) &&
    ((q.st == ST_IBIT) ? ibit_low : q.sda_low);
  assign SCL_OE = en && f_i2c(mode) &&
    (q.scl_low || (f_i2c_s(mode) && !q.ctl[`SSP_CKP]));
  assign PORT_ENABLED = en;
  assign SLEW_LIMIT = en && f_i2c(mode) && !q.sample_phase;
  assign BYTE_EVENT = q.byte_ev;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  master_no_ovf_a: assert property (f_spi_m(mode) && !q.ctl[`SSP_OVF] && !req
    |=> !q.ctl[`SSP_OVF]) else $error("overflow set in SPI master");
  flags_off_a: assert property (!en |-> !q.start && !q.stop)
    else $error("condition flag while disabled");
  stat_write_a: assert property (req && WB_WE_I && WB_SEL_I[0] &&
    WB_ADR_I == `SSP_STAT_ADR |=> q.sample_phase == $past(WB_DAT_I[7]) && q.ack)
    else $error("status write not taken");
  write_collision_flag_set_a: assert property (req && WB_WE_I && WB_SEL_I[0] &&
    WB_ADR_I == `SSP_BUF_ADR && collide |=> q.ctl[`SSP_WRITE_COLLISION_FLAG]) else $error("collision missed");
  write_collision_flag_hold_a: assert property (q.ctl[`SSP_WRITE_COLLISION_FLAG] && !(req && WB_WE_I &&
    WB_ADR_I == `SSP_CTRL_ADR) |=> q.ctl[`SSP_WRITE_COLLISION_FLAG]) else $error("collision flag lost");
  byte_load_a: assert property (sif.done && !q.bf && !req && f_spi_m(mode)
    |=> q.bf && q.bufr == $past(sif.rx_byte) && BYTE_EVENT) else $error("byte not buffered");
  slave_ovf_a: assert property (sif.done && q.bf && f_spi_s(mode)
    |=> q.ctl[`SSP_OVF] && $stable(q.bufr)) else $error("overrun not flagged");
  tx_full_a: assert property (q.st == ST_IBIT && q.kind == K_TX && q.e < 5'h0F
    |-> q.bf) else $error("buffer full dropped during data");
  sck_idle_a: assert property (q.st == ST_IDLE ##1 q.st == ST_IDLE && $stable(q.ctl)
    |-> SCK_O == q.ctl[`SSP_CKP]) else $error("wrong idle clock level");
  // Cycles spent in the current SPI byte; the timer-paced mode has no bound of its own
  logic [9:0] spi_cyc_q;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      spi_cyc_q <= 10'h000;
    end else begin
      spi_cyc_q <= (q.st == ST_SPI) ? spi_cyc_q + 10'h001 : 10'h000;
    end
  end
  // 600 cycles leaves room over the 544 of the slowest divider
  spi_len_a: assert property (q.st == ST_SPI && mode != `SSP_M_SPI_TMR
    |-> spi_cyc_q < 10'h258) else $error("SPI byte too long");

  spi_done_c: cover property (q.st == ST_SPI ##1 q.st == ST_IDLE);
  start_seen_c: cover property (!q.start ##1 q.start);
  overflow_c: cover property (!q.ctl[`SSP_OVF] ##1 q.ctl[`SSP_OVF]);
endmodule
